/* File: design/esp_params.svh */
// Constants for the encoder serial programming port.
`ifndef ESP_PARAMS_SVH
`define ESP_PARAMS_SVH

`define ESP_CLK_MHZ          50
`define ESP_IDLE_TIMEOUT_NS  100000
`define ESP_DATA_W           8
`define ESP_ADDR_W           6
`define ESP_PREFIX_READ      2'b10
`define ESP_PREFIX_WRITE     2'b01
`define ESP_CMD_LAST         4'h7
`define ESP_FRAME_LAST       4'hF
`define ESP_SEL_PROGRAM      1'b0
`define ESP_DO_IDLE          1'b1
`define ESP_ADDR_RESERVED0   6'h00
`define ESP_ADDR_RESERVED1   6'h01
`define ESP_ADDR_ZERO_LO     6'h02
`define ESP_ADDR_ZERO_HI     6'h03
`define ESP_ADDR_CONFIG0     6'h04
`define ESP_ADDR_CONFIG1     6'h05
`define ESP_ADDR_CONFIG2     6'h06
`define ESP_ADDR_UNLOCK      6'h10
`define ESP_ADDR_BURN_RSV    6'h11
`define ESP_ADDR_BURN_ZERO   6'h12
`define ESP_ADDR_BURN_CFG    6'h13
`define ESP_ADDR_OPEN_EXTRA  6'h1B
`define ESP_KEY_UNLOCK       8'hAB
`define ESP_KEY_BURN_RSV     8'hA1
`define ESP_KEY_BURN_ZERO    8'hA2
`define ESP_KEY_BURN_CFG     8'hA3
`define ESP_REG_RESET        8'h00
`define ESP_BURN_RSV_BIT     0
`define ESP_BURN_ZERO_BIT    1
`define ESP_BURN_CFG_BIT     2

`endif

/* File: design/esp_pkg.sv */
// Types for the encoder serial programming port.
package esp_pkg;
  typedef enum logic [2:0] {
    ESP_IDLE  = 3'b000,
    ESP_CMD   = 3'b001,
    ESP_READ  = 3'b010,
    ESP_WRITE = 3'b011,
    ESP_SKIP  = 3'b100
  } esp_state_type;
endpackage

/* File: design/esp_sync.sv */
// Three-stage input synchroniser that accepts a change once stages two and three agree.
`timescale 1ns/1ns
module esp_sync #(
  parameter int           WIDTH     = 3,
  parameter logic [WIDTH-1:0] RESET_VAL = '1
) (
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] stable_out
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] stable;
  } esp_sync_state_type;

  esp_sync_state_type st_reg;
  esp_sync_state_type st_next;

  always_comb begin
    st_next    = st_reg;
    st_next.s1 = async_in;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    for (int i = 0; i < WIDTH; i++) begin
      if (st_reg.s2[i] == st_reg.s3[i]) begin
        st_next.stable[i] = st_reg.s3[i];
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_reg <= {RESET_VAL, RESET_VAL, RESET_VAL, RESET_VAL};
    end else begin
      st_reg <= st_next;
    end
  end

  assign stable_out = st_reg.stable;
endmodule

/* File: design/esp_otp_port.sv */
// Serial register programming port with unlock and one-time-programmable burn commands.
//
// Summary of operation
// RULE1: Interface select low puts the shared pins into register programming.
// RULE2: Interface select high hands the shared pins to the position read-out.
// RULE3: Host clocks the programming link between 10 kHz and 1 MHz.
// RULE4: Read command is prefix 10 then six address bits, MSB first.
// RULE5: After a read command, eight data bits leave on data out.
// RULE6: Data out changes after falling clock edges; host samples on rising edges.
// RULE7: Write frame is prefix 01, six address bits, eight data bits.
// RULE8: Clock and data in idle high between transfers.
// RULE9: Clock stays high across select changes; wait 1 us before transfers.
// RULE10: Clock stays high at least 300 ns between commands.
// RULE11: Host should read a register back after writing it.
// RULE12: Key 0xAB at 0x10 unlocks; 0x00-0x03, 0x10-0x12, 0x1B always open.
// RULE13: Key 0xA1 at 0x11 burns reserved bytes 0x00 and 0x01.
// RULE14: Key 0xA2 at 0x12 burns zero offset bytes 0x02 and 0x03.
// RULE15: Key 0xA3 at 0x13 burns configuration bytes 0x04 to 0x06.
// RULE16: Zero offset low byte sits at 0x02, high byte at 0x03.
// RULE17: Locked writes and frames with unknown prefixes are ignored.
// RULE18: A frame starts at the first falling edge after idle; partials discarded.
`timescale 1ns/1ns
`include "esp_params.svh"
module esp_otp_port
  import esp_pkg::*;
#(
  parameter int IDLE_TIMEOUT_CYCLES = `ESP_IDLE_TIMEOUT_NS * `ESP_CLK_MHZ / 1000
) (
  input  wire logic        CLK_IN,
  input  wire logic        RST_N_IN,
  input  wire logic        INTERFACE_SELECT_IN,
  input  wire logic        SHARED_SERIAL_CLOCK_PIN_IN,
  input  wire logic        SHARED_LOAD_OR_DATAIN_PIN_IN,
  output logic             SHARED_DATAOUT_PIN_OUT,
  output logic             SHARED_DATAOUT_PIN_OE_OUT,
  output logic             POSITION_READOUT_ACTIVE_OUT,
  output logic             REGS_UNLOCKED_OUT,
  output logic [15:0]      ZERO_POSITION_OFFSET_OUT,
  output logic [2:0]       OTP_BURN_PULSE_OUT,
  output logic [2:0]       OTP_BURNED_OUT,
  output logic [6:0][7:0]  OTP_IMAGE_OUT
);
  typedef struct packed {
    esp_state_type  state;
    logic [3:0]     cnt;
    logic [15:0]    sh;
    logic [7:0]     rd;
    logic           sclk_prev;
    logic [15:0]    idle_cnt;
    logic           dout;
    logic           doe;
    logic           ssi;
    logic           unlocked;
    logic [2:0]     burned;
    logic [2:0]     burn_pulse;
    logic [6:0][7:0] otp;
    logic [63:0][7:0] regs;
  } esp_port_state_type;

  esp_port_state_type st_reg;
  esp_port_state_type st_next;
  logic [2:0]         pins_stable;
  logic               sel;
  logic               sclk;
  logic               din;

  esp_sync #(
    .WIDTH     (3),
    .RESET_VAL (3'h7)
  ) u_sync (
    .clk_in     (CLK_IN),
    .rst_n_in   (RST_N_IN),
    .async_in   ({INTERFACE_SELECT_IN, SHARED_SERIAL_CLOCK_PIN_IN,
                  SHARED_LOAD_OR_DATAIN_PIN_IN}),
    .stable_out (pins_stable)
  );

  assign sel  = pins_stable[2];
  assign sclk = pins_stable[1];
  assign din  = pins_stable[0];

  // Addresses that stay writable without the unlock key.
  function automatic logic esp_always_open(input logic [`ESP_ADDR_W-1:0] a);
    esp_always_open = (a == `ESP_ADDR_RESERVED0) || (a == `ESP_ADDR_RESERVED1) ||
                      (a == `ESP_ADDR_ZERO_LO) || (a == `ESP_ADDR_ZERO_HI) ||
                      (a == `ESP_ADDR_UNLOCK) || (a == `ESP_ADDR_BURN_RSV) ||
                      (a == `ESP_ADDR_BURN_ZERO) || (a == `ESP_ADDR_OPEN_EXTRA);
  endfunction

  // Command registers are write-only and read back as zero.
  function automatic logic esp_write_only(input logic [`ESP_ADDR_W-1:0] a);
    esp_write_only = (a == `ESP_ADDR_UNLOCK) || (a == `ESP_ADDR_BURN_RSV) ||
                     (a == `ESP_ADDR_BURN_ZERO) || (a == `ESP_ADDR_BURN_CFG);
  endfunction

  logic                   fall;
  logic                   rise;
  logic [15:0]            sh_shift;
  logic [`ESP_ADDR_W-1:0] cmd_addr;
  logic [`ESP_ADDR_W-1:0] wr_addr;
  logic [7:0]             wr_data;

  always_comb begin
    st_next            = st_reg;
    fall               = st_reg.sclk_prev & ~sclk;
    rise               = ~st_reg.sclk_prev & sclk;
    sh_shift           = {st_reg.sh[14:0], din};
    cmd_addr           = sh_shift[`ESP_ADDR_W-1:0];
    wr_addr            = sh_shift[13:8];
    wr_data            = sh_shift[7:0];
    st_next.sclk_prev  = sclk;
    st_next.burn_pulse = 3'h0;
    st_next.ssi        = (sel != `ESP_SEL_PROGRAM); // RULE2
    st_next.doe        = (sel == `ESP_SEL_PROGRAM); // RULE1

    if (fall || !sclk) begin
      st_next.idle_cnt = 16'h0000;
    end else if (st_reg.idle_cnt != 16'hFFFF) begin
      st_next.idle_cnt = st_reg.idle_cnt + 16'h0001;
    end

    if (sel != `ESP_SEL_PROGRAM) begin
      st_next.state = ESP_IDLE; // RULE18
      st_next.dout  = `ESP_DO_IDLE;
    end else if (st_reg.state != ESP_IDLE &&
                 st_reg.idle_cnt >= IDLE_TIMEOUT_CYCLES[15:0]) begin
      st_next.state = ESP_IDLE; // RULE18
      st_next.dout  = `ESP_DO_IDLE;
    end else begin
      unique case (st_reg.state)
        ESP_IDLE: begin
          if (fall) begin
            st_next.state = ESP_CMD; // RULE18
            st_next.cnt   = 4'h0;
          end
        end
        ESP_CMD: begin
          if (rise) begin
            st_next.sh  = sh_shift; // RULE4
            st_next.cnt = st_reg.cnt + 4'h1;
            if (st_reg.cnt == `ESP_CMD_LAST) begin
              if (sh_shift[7:6] == `ESP_PREFIX_READ) begin
                st_next.state = ESP_READ;
                st_next.rd    = esp_write_only(cmd_addr) ? `ESP_REG_RESET
                                                         : st_reg.regs[cmd_addr]; // RULE5
              end else if (sh_shift[7:6] == `ESP_PREFIX_WRITE) begin
                st_next.state = ESP_WRITE; // RULE7
              end else begin
                st_next.state = ESP_SKIP; // RULE17
              end
            end
          end
        end
        ESP_READ: begin
          if (fall) begin
            st_next.dout = st_reg.rd[7]; // RULE6
            st_next.rd   = {st_reg.rd[6:0], 1'b0};
          end
          if (rise) begin
            st_next.cnt = st_reg.cnt + 4'h1;
            if (st_reg.cnt == `ESP_FRAME_LAST) begin
              st_next.state = ESP_IDLE; // RULE5
              st_next.dout  = `ESP_DO_IDLE;
            end
          end
        end
        ESP_WRITE: begin
          if (rise) begin
            st_next.sh  = sh_shift;
            st_next.cnt = st_reg.cnt + 4'h1;
            if (st_reg.cnt == `ESP_FRAME_LAST) begin
              st_next.state = ESP_IDLE;
              if (st_reg.unlocked || esp_always_open(wr_addr)) begin // RULE17
                if (!esp_write_only(wr_addr)) begin
                  st_next.regs[wr_addr] = wr_data; // RULE16
                end
                if (wr_addr == `ESP_ADDR_UNLOCK) begin
                  st_next.unlocked = (wr_data == `ESP_KEY_UNLOCK); // RULE12
                end
                if (wr_addr == `ESP_ADDR_BURN_RSV && wr_data == `ESP_KEY_BURN_RSV &&
                    !st_reg.burned[`ESP_BURN_RSV_BIT]) begin
                  st_next.otp[0] = st_reg.regs[`ESP_ADDR_RESERVED0]; // RULE13
                  st_next.otp[1] = st_reg.regs[`ESP_ADDR_RESERVED1];
                  st_next.burned[`ESP_BURN_RSV_BIT]     = 1'b1;
                  st_next.burn_pulse[`ESP_BURN_RSV_BIT] = 1'b1;
                end
                if (wr_addr == `ESP_ADDR_BURN_ZERO && wr_data == `ESP_KEY_BURN_ZERO &&
                    !st_reg.burned[`ESP_BURN_ZERO_BIT]) begin
                  st_next.otp[2] = st_reg.regs[`ESP_ADDR_ZERO_LO]; // RULE14
                  st_next.otp[3] = st_reg.regs[`ESP_ADDR_ZERO_HI];
                  st_next.burned[`ESP_BURN_ZERO_BIT]     = 1'b1;
                  st_next.burn_pulse[`ESP_BURN_ZERO_BIT] = 1'b1;
                end
                if (wr_addr == `ESP_ADDR_BURN_CFG && wr_data == `ESP_KEY_BURN_CFG &&
                    !st_reg.burned[`ESP_BURN_CFG_BIT]) begin
                  st_next.otp[4] = st_reg.regs[`ESP_ADDR_CONFIG0]; // RULE15
                  st_next.otp[5] = st_reg.regs[`ESP_ADDR_CONFIG1];
                  st_next.otp[6] = st_reg.regs[`ESP_ADDR_CONFIG2];
                  st_next.burned[`ESP_BURN_CFG_BIT]     = 1'b1;
                  st_next.burn_pulse[`ESP_BURN_CFG_BIT] = 1'b1;
                end
              end
            end
          end
        end
        ESP_SKIP: begin
          // An unknown frame is dropped until the clock idles out.
          st_next.state = ESP_SKIP; // RULE17
        end
        default: begin
          st_next.state = ESP_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      st_reg           <= '0;
      st_reg.state     <= ESP_IDLE;
      st_reg.sclk_prev <= 1'b1;
      st_reg.dout      <= `ESP_DO_IDLE;
      st_reg.ssi       <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign SHARED_DATAOUT_PIN_OUT      = st_reg.dout;
  assign SHARED_DATAOUT_PIN_OE_OUT   = st_reg.doe;
  assign POSITION_READOUT_ACTIVE_OUT = st_reg.ssi;
  assign REGS_UNLOCKED_OUT           = st_reg.unlocked;
  assign ZERO_POSITION_OFFSET_OUT    = {st_reg.regs[`ESP_ADDR_ZERO_HI], // RULE16
                                        st_reg.regs[`ESP_ADDR_ZERO_LO]};
  assign OTP_BURN_PULSE_OUT          = st_reg.burn_pulse;
  assign OTP_BURNED_OUT              = st_reg.burned;
  assign OTP_IMAGE_OUT               = st_reg.otp;
endmodule

/* File: dv/esp_otp_port_monitor.sv */
// Concurrent checks on the programming port outputs.
`timescale 1ns/1ns
module esp_otp_port_monitor (
  input wire logic            CLK_IN,
  input wire logic            RST_N_IN,
  input wire logic            INTERFACE_SELECT_IN,
  input wire logic            SHARED_SERIAL_CLOCK_PIN_IN,
  input wire logic            SHARED_DATAOUT_PIN_OUT,
  input wire logic            SHARED_DATAOUT_PIN_OE_OUT,
  input wire logic            POSITION_READOUT_ACTIVE_OUT,
  input wire logic [2:0]      OTP_BURN_PULSE_OUT,
  input wire logic [2:0]      OTP_BURNED_OUT,
  input wire logic [6:0][7:0] OTP_IMAGE_OUT
);
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RST_N_IN);
  a_prog_drives_pin: assert property (!INTERFACE_SELECT_IN [*8] |->
    SHARED_DATAOUT_PIN_OE_OUT) else $error("data out not driven in programming mode");
  a_readout_owns_pins: assert property (INTERFACE_SELECT_IN [*8] |->
    POSITION_READOUT_ACTIVE_OUT && !SHARED_DATAOUT_PIN_OE_OUT) else $error("pins not released");
  a_idle_out_high: assert property (SHARED_SERIAL_CLOCK_PIN_IN [*8] |=>
    SHARED_DATAOUT_PIN_OUT) else $error("data out low while link idle");
  a_burn_pulse_short: assert property (|OTP_BURN_PULSE_OUT |=> !(|OTP_BURN_PULSE_OUT))
    else $error("burn pulse longer than one cycle");
  a_burn_sets_flag: assert property (|OTP_BURN_PULSE_OUT |=>
    (OTP_BURNED_OUT & $past(OTP_BURN_PULSE_OUT)) == $past(OTP_BURN_PULSE_OUT))
    else $error("no flag");
  a_burn_only_once: assert property (
    (OTP_BURN_PULSE_OUT & $past(OTP_BURNED_OUT)) == 3'h0) else $error("group burned twice");
  a_burned_sticky: assert property (1'b1 |=>
    (OTP_BURNED_OUT & $past(OTP_BURNED_OUT)) == $past(OTP_BURNED_OUT)) else $error("flag lost");
  a_image_needs_burn: assert property ($changed(OTP_IMAGE_OUT) |->
    |OTP_BURN_PULSE_OUT) else $error("image without burn");
endmodule
bind esp_otp_port esp_otp_port_monitor u_esp_otp_port_monitor (.*);

/* File: dv/esp_host_model.sv */
// Serial master model that frames commands for the programming port.
`timescale 1ns/1ns
module esp_host_model (
  input  wire logic clk_in,
  input  wire logic do_in,
  output logic      sclk_out,
  output logic      din_out,
  output logic      sel_out
);
  initial begin
    sclk_out = 1'b1;
    din_out = 1'b1;
    sel_out = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  // Data out is sampled two cycles into the high phase, once its latency has passed.
  // The link runs above the host's top rate to keep runs short; each phase spans four clocks.
  task automatic xfer(input logic [15:0] f, output logic [7:0] r);
    for (int i = 15; i >= 0; i--) begin
      sclk_out <= 1'b0;
      din_out <= f[i];
      tick(4);
      sclk_out <= 1'b1;
      tick(2);
      r = {r[6:0], do_in};
      tick(2);
    end
    din_out <= 1'b1;
    tick(16);
  endtask
  // Clocks only the leading bits of a frame, then idles past the port's frame timeout.
  task automatic part(input logic [15:0] f, input int n);
    for (int i = 15; i > 15 - n; i--) begin
      sclk_out <= 1'b0;
      din_out <= f[i];
      tick(4);
      sclk_out <= 1'b1;
      tick(4);
    end
    din_out <= 1'b1;
    tick(60);
  endtask
  // The clock is already high here, so the select change is safe.
  task automatic select(input logic s);
    sel_out <= s;
    tick(50);
  endtask
endmodule

/* File: dv/tb_esp_otp_port.sv */
// Self-checking bench for the serial programming port.
`timescale 1ns/1ns
`include "esp_params.svh"
module tb_esp_otp_port;
  logic            clk, rst_n, sclk, din, sel, dout, oe, ro, unl, unl_m;
  logic [15:0]     zoff;
  logic [2:0]      pls, brn, eb;
  logic [6:0][7:0] img;
  logic [7:0]      mem [64];
  logic [7:0]      rd, v;
  logic [5:0]      a;
  int              n_fail, checks_done, cyc, n_burn;
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  esp_otp_port #(.IDLE_TIMEOUT_CYCLES(50)) u_esp_otp_port (
    .CLK_IN(clk), .RST_N_IN(rst_n), .INTERFACE_SELECT_IN(sel),
    .SHARED_SERIAL_CLOCK_PIN_IN(sclk), .SHARED_LOAD_OR_DATAIN_PIN_IN(din),
    .SHARED_DATAOUT_PIN_OUT(dout), .SHARED_DATAOUT_PIN_OE_OUT(oe),
    .POSITION_READOUT_ACTIVE_OUT(ro), .REGS_UNLOCKED_OUT(unl),
    .ZERO_POSITION_OFFSET_OUT(zoff), .OTP_BURN_PULSE_OUT(pls),
    .OTP_BURNED_OUT(brn), .OTP_IMAGE_OUT(img));
  esp_host_model u_esp_host_model (.clk_in(clk), .do_in(dout), .sclk_out(sclk),
    .din_out(din), .sel_out(sel));
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  function automatic logic [7:0] exp_rd(logic [5:0] ad);
    return (ad inside {[6'h10:6'h13]}) ? 8'h00 : mem[ad];
  endfunction
  function automatic int grp(int i);
    return i < 2 ? 0 : (i < 4 ? 1 : 2);
  endfunction
  task automatic wr(input logic [5:0] ad, input logic [7:0] d);
    u_esp_host_model.xfer({`ESP_PREFIX_WRITE, ad, d}, rd);
    if (!(ad inside {[6'h10:6'h13]}) && (unl_m || ad < 6'h04 || ad == 6'h1B)) mem[ad] = d;
    if (ad == `ESP_ADDR_UNLOCK) unl_m = (d == `ESP_KEY_UNLOCK);
  endtask
  task automatic rdchk(input logic [5:0] ad);
    u_esp_host_model.xfer({`ESP_PREFIX_READ, ad, 8'hFF}, rd);
    check(16'(rd), 16'(exp_rd(ad)));
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    n_burn <= n_burn + $countones(pls);
    if (cyc == 30000) begin
      n_fail++;
      end_of_test;
    end
  end
  initial begin
    rst_n = 1'b0;
    n_fail = 0;
    checks_done = 0;
    cyc = 0;
    n_burn = 0;
    unl_m = 1'b0;
    eb = 3'h0;
    foreach (mem[i]) mem[i] = 8'h00;
    v = 8'($urandom(32'hBEF7));
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (60) @(posedge clk);
    for (int i = 0; i < 7; i++) begin
      wr(6'(i), 8'($urandom));
      rdchk(6'(i));
    end
    wr(6'h1B, 8'($urandom));
    rdchk(6'h1B);
    check(zoff, {mem[3], mem[2]});
    $display("test locked done");
    for (int p = 0; p < 4; p += 3) begin
      u_esp_host_model.xfer({2'(p), 6'h02, 8'h5A}, rd);
      repeat (60) @(posedge clk);
      rdchk(6'h02);
    end
    u_esp_host_model.part({`ESP_PREFIX_WRITE, 6'h1B, v}, 12);
    rdchk(6'h1B);
    $display("test prefix done");
    wr(`ESP_ADDR_UNLOCK, `ESP_KEY_UNLOCK);
    check(16'(unl), 16'h1);
    rdchk(`ESP_ADDR_UNLOCK);
    for (int i = 0; i < 8; i++) begin
      a = (i < 3) ? 6'(4 + i) : 6'($urandom);
      if (a inside {[6'h10:6'h13]}) a = a ^ 6'h20;
      wr(a, 8'($urandom));
      rdchk(a);
    end
    $display("test unlock done");
    wr(`ESP_ADDR_BURN_RSV, 8'h00);
    check(16'(brn), 16'h0000);
    for (int k = 0; k < 3; k++) begin
      wr(6'(`ESP_ADDR_BURN_RSV + k), 8'(`ESP_KEY_BURN_RSV + k));
      eb[k] = 1'b1;
      check(16'(brn), 16'(eb));
      check(16'(n_burn), 16'(k + 1));
      for (int i = 0; i < 7; i++)
        if (grp(i) <= k) check(16'(img[i]), 16'(mem[i]));
    end
    v = mem[0];
    wr(`ESP_ADDR_RESERVED0, ~v);
    rdchk(`ESP_ADDR_RESERVED0);
    wr(`ESP_ADDR_BURN_RSV, `ESP_KEY_BURN_RSV);
    check(16'(img[0]), 16'(v));
    check(16'(n_burn), 16'h0003);
    $display("test burn done");
    wr(`ESP_ADDR_UNLOCK, 8'h00);
    check(16'(unl), 16'h0);
    u_esp_host_model.select(1'b1);
    check(16'({ro, oe}), 16'h2);
    u_esp_host_model.select(1'b0);
    check(16'({ro, oe}), 16'h1);
    $display("test select done");
    end_of_test;
  end
endmodule
